// File: common/ime_pkg.sv
package ime_pkg;
  localparam logic [3:0] OFS_BUF    = 4'h0;
  localparam logic [3:0] OFS_BAUD   = 4'h4;
  localparam logic [3:0] OFS_CTL    = 4'h8;
  localparam logic [3:0] OFS_STAT   = 4'hC;
  localparam logic [7:0] BAUD_RESET = 8'h04;
  localparam logic [7:0] BRG_ZERO   = 8'h00;
  localparam logic [7:0] BRG_ONE    = 8'h01;
  localparam logic [3:0] BIT_FIRST  = 4'h0;
  localparam logic [3:0] BIT_LAST   = 4'h7;
  localparam logic [3:0] BIT_ACK    = 4'h8;
  localparam logic [3:0] BIT_ONE    = 4'h1;
  localparam int REQ_W       = 5;
  localparam int REQ_START   = 0;
  localparam int REQ_RESTART = 1;
  localparam int REQ_STOP    = 2;
  localparam int REQ_RCV     = 3;
  localparam int REQ_ACKEN   = 4;
  localparam int CTL_ACKDT   = 5;
  localparam int FLG_W       = 6;
  localparam int FLG_BF      = 0;
  localparam int FLG_WRITE_COLLISION_FLAG    = 1;
  localparam int FLG_EVENT   = 2;
  localparam int FLG_BCOL    = 3;
  localparam int FLG_BEGIN   = 4;
  localparam int FLG_STOP    = 5;
  localparam int HTRANS_ACT  = 1;
  typedef enum logic [4:0] {
    ST_IDLE, ST_S_WAIT, ST_S_HOLD,
    ST_R_LOW, ST_R_SCLH, ST_R_SDAL, ST_R_END,
    ST_TX_LOW, ST_TX_HIGH, ST_RX_LOW, ST_RX_HIGH,
    ST_ACK_LOW, ST_ACK_HIGH,
    ST_P_SDAL, ST_P_SCLH, ST_P_SDAH
  } ime_state_t;
endpackage

// File: hdl/ime_top.sv
module ime_top
  import ime_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe_n,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_n
);

  function automatic logic is_high(input ime_state_t s);
    is_high = (s == ST_TX_HIGH) || (s == ST_RX_HIGH) || (s == ST_ACK_HIGH) ||
              (s == ST_R_SCLH) || (s == ST_P_SCLH);
  endfunction

  function automatic logic [REQ_W-1:0] first_req(input logic [REQ_W-1:0] v);
    first_req = v & (~v + {{(REQ_W-1){1'b0}}, 1'b1});
  endfunction

  // pin synchronisers
  logic [1:0] pin_in;
  logic [1:0] pin_sync;
  assign pin_in = {sda_i, scl_i};
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_sync
      logic meta_reg;
      logic sync_reg;
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          meta_reg <= 1'b1;
          sync_reg <= 1'b1;
        end
        else
        begin
          meta_reg <= pin_in[g];
          sync_reg <= meta_reg;
        end
      end
      assign pin_sync[g] = sync_reg;
    end
  endgenerate

  logic              scl_s;
  logic              sda_s;
  logic              scl_prev_reg;
  logic              scl_rise;
  logic              scl_fall;
  assign scl_s    = pin_sync[0];
  assign sda_s    = pin_sync[1];
  assign scl_rise = scl_s & ~scl_prev_reg;
  assign scl_fall = ~scl_s & scl_prev_reg;

  // bus slave: zero wait, writes land in the data phase
  logic              acc;
  logic              mapped;
  logic              wr_pend_reg;
  logic [3:0]        wr_addr_reg;
  logic              wr_buf;
  logic              wr_baud;
  logic              wr_ctl;
  logic              wr_stat;
  logic              rd_buf;
  logic [31:0]       rd_mux;
  logic [31:0]       hrdata_reg;
  assign acc     = hsel & hready & htrans[HTRANS_ACT];
  assign mapped  = (haddr[31:4] == 28'h0000000) && (haddr[1:0] == 2'h0);
  assign wr_buf  = wr_pend_reg && (wr_addr_reg == OFS_BUF);
  assign wr_baud = wr_pend_reg && (wr_addr_reg == OFS_BAUD);
  assign wr_ctl  = wr_pend_reg && (wr_addr_reg == OFS_CTL);
  assign wr_stat = wr_pend_reg && (wr_addr_reg == OFS_STAT);
  assign rd_buf  = acc && !hwrite && mapped && (haddr[3:0] == OFS_BUF);

  ime_state_t        state_reg;
  ime_state_t        state_next;
  logic [7:0]        buf_reg;
  logic [7:0]        buf_next;
  logic [7:0]        shift_reg;
  logic [7:0]        shift_next;
  logic [7:0]        baud_reg;
  logic [7:0]        brg_reg;
  logic [3:0]        bit_reg;
  logic [3:0]        bit_next;
  logic [REQ_W-1:0]  ctl_req_reg;
  logic [REQ_W-1:0]  ctl_req_next;
  logic [REQ_W-1:0]  req_done;
  logic              ack_dt_reg;
  logic              ack_stat_reg;
  logic              ack_stat_next;
  logic [FLG_W-1:0]  flags_reg;
  logic [FLG_W-1:0]  flag_set;
  logic [FLG_W-1:0]  flag_clr;
  logic              scl_low_next;
  logic              sda_low_next;
  logic              wait_load;
  logic              brg_load;
  logic              tmo;
  logic              busy;
  logic              tx_go;
  logic              bf_hw_clr;

  assign rd_mux = !mapped ? 32'h00000000 :
                  (haddr[3:0] == OFS_BUF)  ? {24'h000000, buf_reg} :
                  (haddr[3:0] == OFS_BAUD) ? {24'h000000, baud_reg} :
                  (haddr[3:0] == OFS_CTL)  ? {25'h0000000, ack_stat_reg, ack_dt_reg, ctl_req_reg} :
                  {26'h0000000, flags_reg};

  // any pending request counts as busy; nothing is queued behind it
  assign busy  = (state_reg != ST_IDLE) || (ctl_req_reg != '0);
  assign tx_go = wr_buf && !busy;
  assign tmo   = (brg_reg == BRG_ZERO);
  // hold the counter at reload while a wait is pending; R_END keeps the count
  assign brg_load = wait_load || ((state_next != state_reg) && (state_next != ST_R_END));

  // set wins over a software clear
  assign flag_clr = ({FLG_W{wr_stat}} & {hwdata[FLG_W-1:1], 1'b0}) |
                    {{(FLG_W-1){1'b0}}, bf_hw_clr | rd_buf};

  always_comb
  begin
    state_next    = state_reg;
    scl_low_next  = ~scl_oe_n;
    sda_low_next  = ~sda_oe_n;
    shift_next    = shift_reg;
    bit_next      = bit_reg;
    buf_next      = buf_reg;
    ack_stat_next = ack_stat_reg;
    wait_load     = is_high(state_reg) && !scl_s;
    req_done      = '0;
    flag_set      = '0;
    bf_hw_clr     = 1'b0;
    flag_set[FLG_WRITE_COLLISION_FLAG] = wr_buf && busy;
    case (state_reg)
      ST_IDLE:
      begin
        if (ctl_req_reg[REQ_START])
        begin
          if (!scl_s && !sda_s)
          begin
            flag_set[FLG_BCOL]   = 1'b1;
            req_done[REQ_START]  = 1'b1;
          end
          else if (scl_s && sda_s)
            state_next = ST_S_WAIT;
        end
        else if (ctl_req_reg[REQ_RESTART])
        begin
          scl_low_next = 1'b1;
          state_next   = ST_R_LOW;
        end
        else if (ctl_req_reg[REQ_STOP])
        begin
          scl_low_next = 1'b1;
          sda_low_next = 1'b1;
          state_next   = ST_P_SDAL;
        end
        else if (ctl_req_reg[REQ_RCV])
        begin
          scl_low_next = 1'b1;
          sda_low_next = 1'b0;
          bit_next     = BIT_FIRST;
          state_next   = ST_RX_LOW;
        end
        else if (ctl_req_reg[REQ_ACKEN])
        begin
          scl_low_next = 1'b1;
          sda_low_next = ~ack_dt_reg;
          state_next   = ST_ACK_LOW;
        end
        else if (tx_go)
        begin
          // direction bit is bit 0 of the byte software loads
          shift_next       = hwdata[7:0];
          buf_next         = hwdata[7:0];
          flag_set[FLG_BF] = 1'b1;
          scl_low_next     = 1'b1;
          sda_low_next     = ~hwdata[7];
          bit_next         = BIT_FIRST;
          state_next       = ST_TX_LOW;
        end
      end
      ST_S_WAIT:
      begin
        if (!scl_s || (tmo && !sda_s))
        begin
          flag_set[FLG_BCOL]  = 1'b1;
          req_done[REQ_START] = 1'b1;
          scl_low_next        = 1'b0;
          sda_low_next        = 1'b0;
          state_next          = ST_IDLE;
        end
        else if (tmo)
        begin
          sda_low_next        = 1'b1;
          flag_set[FLG_BEGIN] = 1'b1;
          state_next          = ST_S_HOLD;
        end
      end
      ST_S_HOLD:
      begin
        if (tmo)
        begin
          req_done[REQ_START] = 1'b1;
          flag_set[FLG_EVENT] = 1'b1;
          state_next          = ST_IDLE;
        end
      end
      ST_R_LOW:
      begin
        sda_low_next = 1'b0;
        wait_load    = scl_s;
        if (!scl_s && tmo)
        begin
          if (sda_s)
          begin
            scl_low_next = 1'b0;
            state_next   = ST_R_SCLH;
          end
          else
          begin
            flag_set[FLG_BCOL]    = 1'b1;
            req_done[REQ_RESTART] = 1'b1;
            scl_low_next          = 1'b0;
            state_next            = ST_IDLE;
          end
        end
      end
      ST_R_SCLH, ST_R_SDAL:
      begin
        if ((scl_rise && !sda_s) || scl_fall)
        begin
          flag_set[FLG_BCOL]    = 1'b1;
          req_done[REQ_RESTART] = 1'b1;
          scl_low_next          = 1'b0;
          sda_low_next          = 1'b0;
          state_next            = ST_IDLE;
        end
        else if (scl_s && tmo && (state_reg == ST_R_SCLH))
        begin
          sda_low_next        = 1'b1;
          flag_set[FLG_BEGIN] = 1'b1;
          state_next          = ST_R_SDAL;
        end
        else if (scl_s && tmo)
        begin
          scl_low_next          = 1'b1;
          req_done[REQ_RESTART] = 1'b1;
          state_next            = ST_R_END;
        end
      end
      ST_R_END:
      begin
        if (tmo)
        begin
          flag_set[FLG_EVENT] = 1'b1;
          state_next          = ST_IDLE;
        end
      end
      ST_TX_LOW, ST_RX_LOW, ST_ACK_LOW:
      begin
        if (tmo)
        begin
          scl_low_next = 1'b0;
          state_next   = (state_reg == ST_TX_LOW) ? ST_TX_HIGH :
                         (state_reg == ST_RX_LOW) ? ST_RX_HIGH : ST_ACK_HIGH;
        end
      end
      ST_TX_HIGH:
      begin
        if (scl_rise && (bit_reg == BIT_ACK))
          ack_stat_next = sda_s;
        if (scl_s && tmo)
        begin
          scl_low_next = 1'b1;
          if (bit_reg == BIT_ACK)
          begin
            sda_low_next        = 1'b0;
            flag_set[FLG_EVENT] = 1'b1;
            state_next          = ST_IDLE;
          end
          else
          begin
            bit_next   = bit_reg + BIT_ONE;
            shift_next = {shift_reg[6:0], 1'b0};
            if (bit_reg == BIT_LAST)
            begin
              bf_hw_clr    = 1'b1;
              sda_low_next = 1'b0;
            end
            else
              sda_low_next = ~shift_reg[6];
            state_next = ST_TX_LOW;
          end
        end
      end
      ST_RX_HIGH:
      begin
        if (scl_rise)
          shift_next = {shift_reg[6:0], sda_s};
        if (scl_s && tmo)
        begin
          scl_low_next = 1'b1;
          if (bit_reg == BIT_LAST)
          begin
            buf_next            = shift_next;
            flag_set[FLG_BF]    = 1'b1;
            flag_set[FLG_EVENT] = 1'b1;
            req_done[REQ_RCV]   = 1'b1;
            state_next          = ST_IDLE;
          end
          else
          begin
            bit_next   = bit_reg + BIT_ONE;
            state_next = ST_RX_LOW;
          end
        end
      end
      ST_ACK_HIGH:
      begin
        if (scl_s && tmo)
        begin
          scl_low_next        = 1'b1;
          sda_low_next        = 1'b0;
          req_done[REQ_ACKEN] = 1'b1;
          flag_set[FLG_EVENT] = 1'b1;
          state_next          = ST_IDLE;
        end
      end
      ST_P_SDAL:
      begin
        wait_load = sda_s;
        if (!sda_s && tmo)
        begin
          scl_low_next = 1'b0;
          state_next   = ST_P_SCLH;
        end
      end
      ST_P_SCLH:
      begin
        if (scl_s && tmo)
        begin
          sda_low_next = 1'b0;
          state_next   = ST_P_SDAH;
        end
      end
      ST_P_SDAH:
      begin
        wait_load          = !(sda_s && scl_s);
        flag_set[FLG_STOP] = sda_s && scl_s;
        if (sda_s && scl_s && tmo)
        begin
          req_done[REQ_STOP]  = 1'b1;
          flag_set[FLG_EVENT] = 1'b1;
          state_next          = ST_IDLE;
        end
      end
      default:
      begin
        scl_low_next = 1'b0;
        sda_low_next = 1'b0;
        state_next   = ST_IDLE;
      end
    endcase
  end

  // one request taken at a time, only while idle
  assign ctl_req_next = (wr_ctl && !busy) ? first_req(hwdata[REQ_W-1:0]) :
                        (ctl_req_reg & ~req_done);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_pend_reg  <= 1'b0;
      wr_addr_reg  <= OFS_BUF;
      hrdata_reg   <= 32'h00000000;
      hreadyout    <= 1'b1;
      hresp        <= 1'b0;
      scl_prev_reg <= 1'b1;
      state_reg    <= ST_IDLE;
      buf_reg      <= 8'h00;
      shift_reg    <= 8'h00;
      bit_reg      <= BIT_FIRST;
      baud_reg     <= BAUD_RESET;
      brg_reg      <= BRG_ZERO;
      ctl_req_reg  <= '0;
      ack_dt_reg   <= 1'b0;
      ack_stat_reg <= 1'b0;
      flags_reg    <= '0;
      scl_oe_n     <= 1'b1;
      sda_oe_n     <= 1'b1;
      scl_o        <= 1'b0;
      sda_o        <= 1'b0;
    end
    else
    begin
      wr_pend_reg  <= acc && hwrite && mapped;
      wr_addr_reg  <= haddr[3:0];
      hrdata_reg   <= rd_mux;
      scl_prev_reg <= scl_s;
      state_reg    <= state_next;
      buf_reg      <= buf_next;
      shift_reg    <= shift_next;
      bit_reg      <= bit_next;
      ctl_req_reg  <= ctl_req_next;
      ack_stat_reg <= ack_stat_next;
      flags_reg    <= flag_set | (flags_reg & ~flag_clr);
      scl_oe_n     <= ~scl_low_next;
      sda_oe_n     <= ~sda_low_next;
      if (wr_baud)
        baud_reg <= hwdata[7:0];
      if (wr_ctl)
        ack_dt_reg <= hwdata[CTL_ACKDT];
      if (brg_load)
        brg_reg <= baud_reg;
      else if (!tmo)
        brg_reg <= brg_reg - BRG_ONE;
    end
  end
  assign hrdata = hrdata_reg;

  // host sequencing is left to software; these guard the engine side
  write_collision_flag_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_buf && busy && state_reg != ST_RX_HIGH) |=> (flags_reg[FLG_WRITE_COLLISION_FLAG] && $stable(buf_reg)))
    else $error("busy buffer write not refused");
  ctl_lock_a: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_ctl && ctl_req_reg[REQ_START]) |=> $stable(ctl_req_reg[REQ_ACKEN:REQ_RESTART]))
    else $error("control write taken during start");
  restart_ign_a: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_ctl && state_reg != ST_IDLE && !ctl_req_reg[REQ_RESTART]) |=> !ctl_req_reg[REQ_RESTART])
    else $error("restart accepted while busy");
  begin_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == ST_S_WAIT && tmo && scl_s && sda_s)
    |=> (state_reg == ST_S_HOLD && !sda_oe_n && flags_reg[FLG_BEGIN]))
    else $error("start did not drive sda low");
  start_end_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == ST_S_HOLD && tmo)
    |=> (!ctl_req_reg[REQ_START] && flags_reg[FLG_EVENT] && !sda_oe_n && state_reg == ST_IDLE))
    else $error("start did not complete");
  coll_start_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == ST_S_WAIT && !scl_s)
    |=> (flags_reg[FLG_BCOL] && state_reg == ST_IDLE && sda_oe_n && scl_oe_n))
    else $error("start collision not flagged");
  arb_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (is_high(state_reg) && !scl_s && !wr_baud) |=> (brg_reg == baud_reg))
    else $error("counter ran while scl held low");
  tx_start_a: assert property (@(posedge clk) disable iff (!rst_n)
    tx_go |=> (flags_reg[FLG_BF] && state_reg == ST_TX_LOW && !scl_oe_n
               && (sda_oe_n == $past(hwdata[7]))))
    else $error("buffer write did not start transmit");
  bf_clr_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == ST_TX_HIGH && bit_reg == BIT_LAST && scl_s && tmo)
    |=> (!flags_reg[FLG_BF] && sda_oe_n && !scl_oe_n))
    else $error("eighth fall did not free sda");
  ack_cap_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == ST_TX_HIGH && bit_reg == BIT_ACK && scl_rise) |=> (ack_stat_reg == $past(sda_s)))
    else $error("ack not captured");
  tx_done_a: assert property (@(posedge clk) disable iff (!rst_n)
    (state_reg == ST_TX_HIGH && bit_reg == BIT_ACK && scl_s && tmo)
    |=> (state_reg == ST_IDLE && flags_reg[FLG_EVENT] && !scl_oe_n && sda_oe_n) [*2])
    else $error("ninth clock end wrong");

endmodule // ime_top

// File: testbench/ime_slave_model.sv
module ime_slave_model
  #(parameter logic [6:0] ADDR = 7'h3A)
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic       hold,
  output logic            scl_pull,
  output logic            sda_pull,
  output logic      [7:0] byte_o,
  output logic            byte_vld
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       scl_q;
  logic       sda_q;
  logic       first;
  logic [3:0] cnt;
  logic [7:0] sh;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {scl_q, sda_q, first, scl_pull, sda_pull, byte_vld} <= 6'h30;
      cnt <= 4'h0;
      sh <= 8'h00;
      byte_o <= 8'h00;
    end
    else
    begin
      scl_q <= scl;
      sda_q <= sda;
      byte_vld <= 1'b0;
      // grab only a line already low, so no pulse is cut short
      scl_pull <= hold & (~scl | scl_pull);
      if (scl & scl_q & sda_q & ~sda)
      begin
        cnt <= 4'h0;
        first <= 1'b1;
      end
      else if (scl & ~scl_q & (cnt < 4'h9))
      begin
        // bits count on rises: the fall that ends a start is no bit
        cnt <= cnt + 4'h1;
        if (cnt < 4'h8)
          sh <= {sh[6:0], sda};
      end
      else if (~scl & scl_q)
      begin
        if (cnt == 4'h8)
        begin
          byte_o <= sh;
          byte_vld <= 1'b1;
          sda_pull <= ~first | (sh[7:1] == ADDR);
          first <= 1'b0;
        end
        if (cnt == 4'h9)
        begin
          cnt <= 4'h0;
          sda_pull <= 1'b0;
        end
      end
    end
  end
endmodule // ime_slave_model

// File: testbench/tb_ime_top.sv
module tb_ime_top
  import ime_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] A_BUF = 32'(OFS_BUF);
  localparam logic [31:0] A_BAUD = 32'(OFS_BAUD);
  localparam logic [31:0] A_CTL = 32'(OFS_CTL);
  localparam logic [31:0] A_ST = 32'(OFS_STAT);
  logic        clk = 0;
  logic        rst_n = 0;
  logic        hsel = 0;
  logic        hwrite = 0;
  logic        hold = 0;
  logic        jam = 0;
  logic        jam_c = 0;
  logic        mon = 0;
  logic        scl_p = 1;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, q, rd_dat;
  logic        hreadyout, hresp, scl_o, scl_oe_n, sda_o, sda_oe_n;
  logic        scl_w, sda_w, scl_pull, sda_pull, bvld;
  logic [7:0]  bdat, r, d;
  logic [31:0] rd_q[$];
  logic [31:0] by_q[$];
  int          err_total = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  int          span = 0;
  event        rd_ev;
  // pull-ups on both wires, any party may pull low
  assign scl_w = (scl_oe_n | scl_o) & ~scl_pull & ~jam & ~jam_c;
  assign sda_w = (sda_oe_n | sda_o) & ~sda_pull & ~jam;
  always #20 clk = ~clk;
  ime_top i_ime_top (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .scl_i(scl_w), .scl_o(scl_o), .scl_oe_n(scl_oe_n),
    .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n(sda_oe_n));
  ime_slave_model i_ime_slave_model (.clk(clk), .rst_n(rst_n), .scl(scl_w),
    .sda(sda_w), .hold(hold), .scl_pull(scl_pull), .sda_pull(sda_pull),
    .byte_o(bdat), .byte_vld(bvld));
  task check(input logic [31:0] s, input logic [31:0] e, input string n);
    samples_checked++;
    if (s !== e)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task end_of_test;
    if (err_total == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task bus(input logic w, input logic [31:0] a, input logic [31:0] dat);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= dat;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task rd(input logic [31:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check({31'h0, hresp}, 32'h0, "bus response");
    rd_q.push_back(e);
    rd_dat = q;
    ->rd_ev;
  endtask
  task waitf(input int b);
    int n;
    n = 0;
    do
    begin
      bus(1'b0, A_ST, 32'h0);
      n++;
    end
    while (q[b] !== 1'b1 && n < 2000);
    if (n >= 2000)
      err_total++;
  endtask
  always @(rd_ev) check(rd_dat, rd_q.pop_front(), "register read");
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    scl_p <= scl_w;
    span <= (scl_w !== scl_p) ? 1 : span + 1;
    if (mon && scl_w !== scl_p)
      check(32'(span >= r + 8'h1), 32'h1, "scl phase length");
    if (bvld === 1'b1)
      check({24'h0, bdat}, by_q.pop_front(), "wire byte");
    if (cyc == 30000)
    begin
      err_total++;
      end_of_test;
    end
  end
  initial
  begin
    void'($urandom(45289));
    r = 8'($urandom_range(4, 1));
    d = 8'($urandom);
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd(A_BAUD, 32'(BAUD_RESET));
    rd(A_ST, 32'h0);
    wr_unmapped: bus(1'b1, 32'h10, 32'hFFFF);
    rd(32'h10, 32'h0);
    bus(1'b1, A_BAUD, {24'h0, r});
    rd(A_BAUD, {24'h0, r});
    mon = 1'b1;
    bus(1'b1, A_CTL, 32'h1);
    bus(1'b1, A_BUF, 32'hAA);
    bus(1'b1, A_CTL, 32'h4);
    waitf(FLG_EVENT);
    check({30'h0, scl_oe_n, sda_oe_n}, 32'h2, "start lines");
    rd(A_CTL, 32'h0);
    rd(A_ST, 32'h16);
    rd(A_BUF, 32'h0);
    bus(1'b1, A_ST, 32'h3E);
    by_q.push_back({24'h0, 7'h3A, 1'b0});
    bus(1'b1, A_BUF, {24'h0, 7'h3A, 1'b0});
    rd(A_ST, 32'h1);
    bus(1'b1, A_BUF, 32'h55);
    waitf(FLG_EVENT);
    check({30'h0, scl_oe_n, sda_oe_n}, 32'h1, "byte end lines");
    rd(A_CTL, 32'h0);
    rd(A_ST, 32'h6);
    bus(1'b1, A_ST, 32'h3E);
    // slave holds scl low through the first low phase of this byte until hold drops
    by_q.push_back({24'h0, d});
    bus(1'b1, A_BUF, {24'h0, d});
    hold <= 1'b1;
    bus(1'b1, A_CTL, 32'h2);
    repeat (60) @(posedge clk);
    hold <= 1'b0;
    waitf(FLG_EVENT);
    rd(A_CTL, 32'h0);
    rd(A_ST, 32'h4);
    bus(1'b1, A_ST, 32'h3E);
    bus(1'b1, A_CTL, 32'h2);
    waitf(FLG_EVENT);
    check({30'h0, scl_oe_n, sda_oe_n}, 32'h0, "restart lines");
    rd(A_CTL, 32'h0);
    rd(A_ST, 32'h14);
    bus(1'b1, A_ST, 32'h3E);
    by_q.push_back({24'h0, 7'h11, 1'b1});
    bus(1'b1, A_BUF, {24'h0, 7'h11, 1'b1});
    waitf(FLG_EVENT);
    rd(A_CTL, 32'h40);
    bus(1'b1, A_ST, 32'h3E);
    // nobody answers the read, so the released wire reads ones
    by_q.push_back(32'hFF);
    bus(1'b1, A_CTL, 32'h8);
    waitf(FLG_EVENT);
    rd(A_ST, 32'h5);
    rd(A_BUF, 32'hFF);
    rd(A_ST, 32'h4);
    bus(1'b1, A_ST, 32'h3E);
    bus(1'b1, A_CTL, 32'h10);
    waitf(FLG_EVENT);
    rd(A_CTL, 32'h40);
    check({30'h0, scl_oe_n, sda_oe_n}, 32'h1, "ack end lines");
    bus(1'b1, A_ST, 32'h3E);
    bus(1'b1, A_CTL, 32'h4);
    waitf(FLG_EVENT);
    check({30'h0, scl_oe_n, sda_oe_n}, 32'h3, "stop lines");
    rd(A_ST, 32'h24);
    bus(1'b1, A_ST, 32'h3E);
    // scl alone pulled low while the start waits its first period
    bus(1'b1, A_CTL, 32'h1);
    jam_c <= 1'b1;
    waitf(FLG_BCOL);
    rd(A_ST, 32'h8);
    check({30'h0, scl_oe_n, sda_oe_n}, 32'h3, "wait abort lines");
    jam_c <= 1'b0;
    bus(1'b1, A_ST, 32'h3E);
    repeat (8) @(posedge clk);
    // both wires held low by a stuck party
    jam <= 1'b1;
    bus(1'b1, A_CTL, 32'h1);
    waitf(FLG_BCOL);
    rd(A_ST, 32'h8);
    check({30'h0, scl_oe_n, sda_oe_n}, 32'h3, "abort lines");
    jam <= 1'b0;
    end_of_test;
  end
endmodule // tb_ime_top
